// ### core/obs_pkg.sv
// Shared constants, types and helpers for the oil input supervisor
package obs_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int CIRC_WAIT_S = 45;
	localparam int CIRC_WAIT_TICKS = CIRC_WAIT_S * 1000 / TICK_MS;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PHASE_W = 8;
	localparam int DELAY_W = 24;
	localparam int CIRC_W = 16;
	localparam int CFG_W = 7;
	localparam int EVT_W = 6;
	localparam int LIVE_W = 7;

	localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h00;
	localparam logic [ADDR_W-1:0] REG_DELAY = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_MASK = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_INPUTS = 8'h10;

	localparam int CFG_LOW_LSB = 0;
	localparam int CFG_HIGH_BIT = 2;
	localparam int CFG_REL_BIT = 3;
	localparam int CFG_GO_BIT = 4;
	localparam int CFG_SHARED_LSB = 5;

	localparam int EVT_LOW = 0;
	localparam int EVT_HIGH = 1;
	localparam int EVT_REL = 2;
	localparam int EVT_GO = 3;
	localparam int EVT_TIMEOUT = 4;
	localparam int EVT_SHARED = 5;

	localparam logic [CFG_W-1:0] CONFIG_RST = 7'h3D;
	localparam logic [DELAY_W-1:0] DELAY_RST = 24'h00_61A8;
	localparam logic [EVT_W-1:0] MASK_RST = 6'h00;

	localparam logic [PHASE_W-1:0] PH_RELEASE = 8'h15;
	localparam logic [PHASE_W-1:0] PH_CIRC_HEAVY = 8'h26;
	localparam logic [PHASE_W-1:0] PH_CIRC_HEAVY_PILOT = 8'h2C;

	typedef enum logic [2:0] {
		FUEL_GAS = 3'b000,
		FUEL_LIGHT = 3'b001,
		FUEL_HEAVY = 3'b010,
		FUEL_LIGHT_PILOT = 3'b011,
		FUEL_HEAVY_PILOT = 3'b100
	} obs_fuel_t;

	typedef enum logic [1:0] {
		LOW_OFF = 2'b00,
		LOW_ACT = 2'b01,
		LOW_FROM_TS = 2'b10
	} obs_low_mode_t;

	typedef enum logic [1:0] {
		SH_OFF = 2'b00,
		SH_FAN = 2'b01,
		SH_RECIRC = 2'b10
	} obs_shared_t;

	function automatic logic is_oil(input obs_fuel_t fuel);
		return fuel != FUEL_GAS;
	endfunction

	function automatic logic is_heavy(input obs_fuel_t fuel);
		return fuel == FUEL_HEAVY || fuel == FUEL_HEAVY_PILOT;
	endfunction
endpackage

// ### core/obs_tick_divider.sv
// Millisecond enable pulse from the system clock
module obs_tick_divider #(
	parameter int CYCLES = obs_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	output logic tick
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

// ### core/obs_reaction_delay.sv
// Loss-of-signal delay counter in system clock cycles
module obs_reaction_delay #(
	parameter int W = obs_pkg::DELAY_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic present,
	input wire logic [W-1:0] limit,
	output logic expired
);
	logic [W-1:0] count;

	// Restarts whenever the signal is back or watching stops
	always_ff @(posedge clk) begin
		if (!resetn || !enable || present) begin
			count <= '0;
		end else if (count < limit) begin
			count <= count + 1'b1;
		end
	end

	assign expired = enable && !present && count >= limit;
endmodule

// ### core/obs_input_supervisor.sv
// Oil-side safety and release input supervisor with register port
//
// Contract
// R1: From-safety-time mode: no pressure wait in preignition
// R2: That mode checks low pressure from first safety
// R3: Deactivated inputs are ignored entirely
// R4: Pressure loss in safety times reacts after delay
// R5: High oil pressure on oil forces safety shutdown
// R6: Oil release expected from phase 21, loss shuts
// R7: Direct-go ends heavy circulation phase 38/44 early
// R8: Circulation waits 45 s, then home run, repeat
// R9: Direct-go evaluated only for heavy fuel trains
// R10: Fan contactor feedback checked after fan command
// R11: Shared input selects fan, recirculation, or off
// R12: Activated mode expects pressure in preignition/phase 44
// R13: Delay counter restarts per loss, trips at limit
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
module obs_input_supervisor #(
	parameter int TICK_CYCLES = obs_pkg::TICK_CYCLES,
	parameter int CIRC_WAIT_TICKS = obs_pkg::CIRC_WAIT_TICKS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [obs_pkg::ADDR_W-1:0] regAddr,
	input wire logic [obs_pkg::DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [obs_pkg::DATA_W-1:0] regRdata,
	input wire obs_pkg::obs_fuel_t fuelSelect,
	input wire logic [obs_pkg::PHASE_W-1:0] phase,
	input wire logic sequenceRun,
	input wire logic preignition,
	input wire logic firstSafetyTime,
	input wire logic secondSafetyTime,
	input wire logic fanCommand,
	input wire logic oilLowPressureSwitch,
	input wire logic oilHighPressureSwitch,
	input wire logic oilStartRelease,
	input wire logic heavyFuelDirectGo,
	input wire logic sharedSwitch,
	output logic safetyShutdown,
	output logic burnerShutdown,
	output logic circulationEnd,
	output logic homeRunRepeat,
	output logic irq
);
	import obs_pkg::*;

	localparam logic [CIRC_W-1:0] CIRC_LIMIT = CIRC_W'(CIRC_WAIT_TICKS);
	localparam logic [CIRC_W-1:0] CIRC_LAST = CIRC_W'(CIRC_WAIT_TICKS - 1);

	// Software registers
	logic [CFG_W-1:0] cfgReg;
	logic [DELAY_W-1:0] delayLimit;
	logic [EVT_W-1:0] status;
	logic [EVT_W-1:0] mask;
	logic [EVT_W-1:0] next_status;

	// Decoded configuration
	obs_low_mode_t lowMode;
	obs_shared_t sharedSel;
	logic highEn;
	logic relEn;
	logic goEn;

	// Supervision state
	logic oilFire;
	logic inSafety;
	logic lowArmed;
	logic lowArmCond;
	logic lowExpired;
	logic lowFault;
	logic highFault;
	logic relFault;
	logic inCirc;
	logic [PHASE_W-1:0] circPhase;
	logic [CIRC_W-1:0] circTimer;
	logic circTimedOut;
	logic goHit;
	logic sharedWatch;
	logic sharedFault;
	logic tick;
	logic [EVT_W-1:0] evtCond;
	logic [EVT_W-1:0] evtQ;
	logic [EVT_W-1:0] evtPulse;
	logic [LIVE_W-1:0] liveView;

	assign lowMode = obs_low_mode_t'(cfgReg[CFG_LOW_LSB +: 2]);
	assign highEn = cfgReg[CFG_HIGH_BIT];
	assign relEn = cfgReg[CFG_REL_BIT];
	assign goEn = cfgReg[CFG_GO_BIT];
	assign sharedSel = obs_shared_t'(cfgReg[CFG_SHARED_LSB +: 2]);

	assign oilFire = sequenceRun && is_oil(fuelSelect);
	assign inSafety = firstSafetyTime || secondSafetyTime;

	obs_tick_divider #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.clk(clk),
		.resetn(resetn),
		.tick(tick)
	);

	// Register writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cfgReg <= CONFIG_RST;
		end else if (regWrite && regAddr == REG_CONFIG) begin
			cfgReg <= regWdata[CFG_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			delayLimit <= DELAY_RST;
		end else if (regWrite && regAddr == REG_DELAY) begin
			delayLimit <= regWdata[DELAY_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			mask <= MASK_RST;
		end else if (regWrite && regAddr == REG_MASK) begin
			mask <= regWdata[EVT_W-1:0];
		end
	end

	// Sticky events, write one to clear, a new event wins
	always_comb begin
		next_status = status;
		if (regWrite && regAddr == REG_STATUS) begin
			next_status = status & ~regWdata[EVT_W-1:0];
		end
		next_status = next_status | evtPulse;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			status <= '0;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			irq <= |(next_status & mask);
		end
	end

	assign liveView = {inCirc, lowArmed, sharedSwitch, heavyFuelDirectGo,
		oilStartRelease, oilHighPressureSwitch, oilLowPressureSwitch};

	// Read data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			regRdata <= '0;
		end else begin
			regRdata <= '0;
			if (regRead) begin
				case (regAddr)
					REG_CONFIG: regRdata <= DATA_W'(cfgReg);
					REG_DELAY: regRdata <= DATA_W'(delayLimit);
					REG_STATUS: regRdata <= DATA_W'(status);
					REG_MASK: regRdata <= DATA_W'(mask);
					REG_INPUTS: regRdata <= DATA_W'(liveView);
					default: regRdata <= '0;
				endcase
			end
		end
	end

	// Low oil pressure arming per mode
	always_comb begin
		case (lowMode)
			LOW_ACT: begin
				if (fuelSelect == FUEL_HEAVY_PILOT) begin
					lowArmCond = phase == PH_CIRC_HEAVY_PILOT
						&& oilLowPressureSwitch; // see R12
				end else begin
					lowArmCond = preignition && oilLowPressureSwitch; // see R12
				end
				lowArmCond = lowArmCond || firstSafetyTime;
			end
			LOW_FROM_TS: lowArmCond = firstSafetyTime; // see R1 see R2
			default: lowArmCond = 1'b0; // see R3
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn || !oilFire) begin
			lowArmed <= 1'b0;
		end else if (lowMode != LOW_ACT && lowMode != LOW_FROM_TS) begin
			lowArmed <= 1'b0; // see R3
		end else if (lowArmCond) begin
			lowArmed <= 1'b1;
		end
	end

	obs_reaction_delay #(
		.W(DELAY_W)
	) u_low_delay (
		.clk(clk),
		.resetn(resetn),
		.enable(lowArmed),
		.present(oilLowPressureSwitch),
		.limit(delayLimit),
		.expired(lowExpired)
	);

	// Loss reacts after the delay only inside the safety times
	assign lowFault = lowArmed && !oilLowPressureSwitch
		&& (inSafety ? lowExpired : 1'b1); // see R4 see R13 see R2

	assign highFault = highEn && oilFire && oilHighPressureSwitch; // see R5

	assign relFault = relEn && oilFire && phase >= PH_RELEASE
		&& !oilStartRelease; // see R6

	// Heavy fuel circulation supervision
	assign circPhase = (fuelSelect == FUEL_HEAVY) ? PH_CIRC_HEAVY
		: PH_CIRC_HEAVY_PILOT; // see R7
	assign inCirc = goEn && sequenceRun && is_heavy(fuelSelect)
		&& phase == circPhase; // see R9 see R3

	always_ff @(posedge clk) begin
		if (!resetn || !inCirc) begin
			circTimer <= '0;
		end else if (tick && circTimer < CIRC_LIMIT) begin
			circTimer <= circTimer + 1'b1; // see R8
		end
	end

	assign circTimedOut = inCirc && circTimer >= CIRC_LIMIT; // see R8
	assign goHit = inCirc && heavyFuelDirectGo && !circTimedOut; // see R7

	// Shared fan contactor / recirculation input
	assign sharedWatch = sequenceRun && fanCommand
		&& (sharedSel == SH_FAN || sharedSel == SH_RECIRC); // see R11 see R10

	obs_reaction_delay #(
		.W(DELAY_W)
	) u_shared_delay (
		.clk(clk),
		.resetn(resetn),
		.enable(sharedWatch),
		.present(sharedSwitch),
		.limit(delayLimit),
		.expired(sharedFault)
	);

	// Rising edges of conditions become events
	assign evtCond = {sharedFault, circTimedOut, goHit, relFault, highFault,
		lowFault};
	assign evtPulse = evtCond & ~evtQ;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			evtQ <= '0;
		end else begin
			evtQ <= evtCond;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			safetyShutdown <= 1'b0;
			burnerShutdown <= 1'b0;
			circulationEnd <= 1'b0;
			homeRunRepeat <= 1'b0;
		end else begin
			safetyShutdown <= evtPulse[EVT_LOW] || evtPulse[EVT_HIGH]; // see R5
			burnerShutdown <= evtPulse[EVT_REL] || evtPulse[EVT_SHARED]; // see R6
			circulationEnd <= evtPulse[EVT_GO]; // see R7
			homeRunRepeat <= evtPulse[EVT_TIMEOUT]; // see R8
		end
	end

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence lossStart;
		lowArmed && inSafety && $fell(oilLowPressureSwitch)
			&& delayLimit > 24'h00_0002;
	endsequence

	sequence goSeen;
		inCirc && heavyFuelDirectGo && !circTimedOut && !evtQ[EVT_GO];
	endsequence

	sequence circLastTick;
		inCirc && tick && circTimer == CIRC_LAST ##1 inCirc;
	endsequence

	low_ts_wait_a: assert property ( // see R1
		lowMode == LOW_FROM_TS && !lowArmed && !firstSafetyTime
		|=> !lowArmed)
		else $error("low pressure armed before first safety time");

	low_ts_arm_a: assert property ( // see R2
		(lowMode == LOW_FROM_TS && oilFire && firstSafetyTime) ##1 oilFire
		|-> lowArmed)
		else $error("low pressure not evaluated from first safety time");

	low_loss_trip_a: assert property ( // see R12
		lowArmed && !oilLowPressureSwitch && !inSafety && !evtQ[EVT_LOW]
		|=> safetyShutdown)
		else $error("low pressure loss without safety shutdown");

	deact_quiet_a: assert property ( // see R3
		!highEn && !relEn && !goEn
		|-> !(highFault || relFault || goHit || circTimedOut))
		else $error("deactivated input acted");

	low_off_quiet_a: assert property ( // see R3
		lowMode != LOW_ACT && lowMode != LOW_FROM_TS |=> !lowArmed)
		else $error("deactivated low pressure input stayed armed");

	delay_hold_a: assert property ( // see R4
		lossStart |-> !lowFault
			##1 (!lowFault || !inSafety || oilLowPressureSwitch))
		else $error("pressure loss tripped before reaction delay");

	delay_expire_a: assert property ( // see R13
		lowArmed && inSafety && !oilLowPressureSwitch && lowExpired
		&& !evtQ[EVT_LOW] |=> safetyShutdown)
		else $error("expired delay did not trip");

	high_trip_a: assert property ( // see R5
		highEn && oilFire && oilHighPressureSwitch && !evtQ[EVT_HIGH]
		|=> safetyShutdown)
		else $error("high oil pressure without safety shutdown");

	high_gas_quiet_a: assert property ( // see R5
		fuelSelect == FUEL_GAS |-> !highFault)
		else $error("high oil switch evaluated on gas");

	release_trip_a: assert property ( // see R6
		relEn && oilFire && phase >= PH_RELEASE && !oilStartRelease
		&& !evtQ[EVT_REL] |=> burnerShutdown)
		else $error("missing oil release without shutdown");

	circ_early_end_a: assert property ( // see R7
		goSeen |=> circulationEnd)
		else $error("direct go did not end circulation");

	circ_timeout_a: assert property ( // see R8
		circLastTick |=> homeRunRepeat)
		else $error("circulation wait did not time out");

	light_fuel_a: assert property ( // see R9
		!is_heavy(fuelSelect) |=> !circulationEnd && !homeRunRepeat)
		else $error("direct go evaluated for non-heavy fuel");

	fan_check_a: assert property ( // see R10
		sharedSel == SH_FAN && sequenceRun && fanCommand && !sharedSwitch
		&& sharedFault && !evtQ[EVT_SHARED] |=> burnerShutdown)
		else $error("fan contactor loss without shutdown");

	shared_off_a: assert property ( // see R11
		sharedSel == SH_OFF |-> !sharedFault)
		else $error("deactivated shared input acted");

	low_pilot_arm_a: assert property ( // see R12
		(lowMode == LOW_ACT && fuelSelect == FUEL_HEAVY_PILOT && sequenceRun
		&& phase == PH_CIRC_HEAVY_PILOT && oilLowPressureSwitch) ##1 oilFire
		|-> lowArmed)
		else $error("pressure in phase 44 not taken");
endmodule

// ### tb/obs_field_switches.sv
// Field pressure switches and release contacts for the supervisor
module obs_field_switches (
	input wire logic clk,
	input wire logic fanCommand,
	input wire logic lowPresent,
	input wire logic highExceeded,
	input wire logic releaseGiven,
	input wire logic directGo,
	input wire logic [7:0] fanLag,
	output logic oilLowPressureSwitch,
	output logic oilHighPressureSwitch,
	output logic oilStartRelease,
	output logic heavyFuelDirectGo,
	output logic sharedSwitch
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] fanAge = 8'h00;
	// Contactor closes after the fan has run fanLag cycles
	always_ff @(posedge clk) begin
		fanAge <= fanCommand ? fanAge + 8'(fanAge != 8'hFF) : 8'h00;
	end
	assign sharedSwitch = fanCommand && fanAge >= fanLag;
	assign oilLowPressureSwitch = lowPresent;
	assign oilHighPressureSwitch = highExceeded;
	assign oilStartRelease = releaseGiven;
	assign heavyFuelDirectGo = directGo;
endmodule

// ### tb/obs_input_supervisor_bench.sv
// Self-checking bench for the oil input supervisor
module obs_input_supervisor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import obs_pkg::*;
	logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0, regRdata, rdata;
	obs_fuel_t fuel = FUEL_GAS;
	logic [PHASE_W-1:0] phase = '0;
	logic run = 0, pre = 0, ts1 = 0, ts2 = 0, fan = 0, lowP = 1, highP = 0;
	logic rel = 1, directGo = 0;
	logic [7:0] lag = 8'h00;
	logic lowSw, highSw, relSw, goSw, sharedSw;
	logic safetyShutdown, burnerShutdown, circulationEnd, homeRunRepeat, irq;
	int fails = 0, check_count = 0, cycles = 0;
	int cnt[4], first[4];

	obs_input_supervisor #(.TICK_CYCLES(4), .CIRC_WAIT_TICKS(10))
		obs_input_supervisor_inst (.clk(clk), .resetn(resetn),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .fuelSelect(fuel),
		.phase(phase), .sequenceRun(run), .preignition(pre),
		.firstSafetyTime(ts1), .secondSafetyTime(ts2), .fanCommand(fan),
		.oilLowPressureSwitch(lowSw), .oilHighPressureSwitch(highSw),
		.oilStartRelease(relSw), .heavyFuelDirectGo(goSw),
		.sharedSwitch(sharedSw), .safetyShutdown(safetyShutdown),
		.burnerShutdown(burnerShutdown), .circulationEnd(circulationEnd),
		.homeRunRepeat(homeRunRepeat), .irq(irq));
	obs_field_switches obs_field_switches_inst (.clk(clk), .fanCommand(fan),
		.lowPresent(lowP), .highExceeded(highP), .releaseGiven(rel),
		.directGo(directGo), .fanLag(lag), .oilLowPressureSwitch(lowSw),
		.oilHighPressureSwitch(highSw), .oilStartRelease(relSw),
		.heavyFuelDirectGo(goSw), .sharedSwitch(sharedSw));

	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 rdata = regRdata;
	endtask
	// Count output pulses over n cycles, noting the first cycle of each
	task automatic watch(input int n);
		logic [3:0] o;
		cnt = '{0, 0, 0, 0};
		first = '{-1, -1, -1, -1};
		for (int i = 1; i <= n; i++) begin
			@(posedge clk);
			#1 o = {homeRunRepeat, circulationEnd, burnerShutdown,
				safetyShutdown};
			for (int k = 0; k < 4; k++) begin
				if (o[k] === 1'b1 && first[k] < 0) first[k] = i;
				if (o[k] === 1'b1) cnt[k]++;
			end
		end
	endtask
	task automatic idle(input logic [31:0] cfg, input obs_fuel_t f);
		wr(REG_CONFIG, cfg);
		run <= 0;
		pre <= 0;
		ts1 <= 0;
		ts2 <= 0;
		fan <= 0;
		lowP <= 1;
		highP <= 0;
		rel <= 1;
		directGo <= 0;
		phase <= '0;
		fuel <= f;
		step(2);
		run <= 1;
	endtask

	task automatic t_regs();
		rd(REG_CONFIG);
		check("config", 32'h3D, rdata);
		rd(REG_DELAY);
		check("delay", 32'h61A8, rdata);
		rd(REG_STATUS);
		check("status", 32'h0, rdata);
		rd(REG_MASK);
		check("mask", 32'h0, rdata);
		rd(REG_INPUTS);
		check("inputs", 32'h05, rdata);
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h14);
		check("unmapped", 32'h0, rdata);
		wr(REG_CONFIG, 32'hFFFF_FFFF);
		rd(REG_CONFIG);
		check("config bits", 32'h7F, rdata);
		wr(REG_DELAY, 32'h8);
	endtask
	task automatic t_high(input logic [31:0] cfg, input obs_fuel_t f,
		input int exp);
		idle(cfg, f);
		highP <= 1;
		watch(4);
		check("high trip", exp, cnt[0]);
		check("high lag", exp ? 1 : -1, first[0]);
	endtask
	task automatic t_low_ts();
		idle(32'h02, FUEL_LIGHT);
		pre <= 1;
		lowP <= 0;
		watch(12);
		check("no preign wait", 0, cnt[0]);
		pre <= 0;
		ts1 <= 1;
		watch(16);
		check("ts low trip", 1, cnt[0]);
		check("ts delay", 1, first[0] >= 8 && first[0] <= 11);
		lowP <= 1;
		ts1 <= 0;
		ts2 <= 1;
		step(3);
		lowP <= 0;
		step(5);
		lowP <= 1;
		step(2);
		lowP <= 0;
		watch(16);
		check("restart", 1, first[0] >= 8 && first[0] <= 11);
	endtask
	task automatic t_low_act();
		idle(32'h01, FUEL_LIGHT);
		pre <= 1;
		step(3);
		pre <= 0;
		lowP <= 0;
		watch(4);
		check("act drop", 1, first[0]);
	endtask
	task automatic t_release();
		idle(32'h08, FUEL_LIGHT);
		phase <= 8'h10;
		rel <= 0;
		watch(4);
		check("before 21", 0, cnt[1]);
		phase <= PH_RELEASE;
		watch(4);
		check("missing", 1, cnt[1]);
		rel <= 1;
		step(2);
		rel <= 0;
		watch(4);
		check("lost", 1, first[1]);
	endtask
	task automatic t_go(input obs_fuel_t f, input logic [7:0] ph,
		input int exp);
		idle(32'h10, f);
		phase <= ph;
		directGo <= 1;
		watch(4);
		check("direct go", exp, cnt[2]);
	endtask
	task automatic t_timeout();
		idle(32'h10, FUEL_HEAVY);
		phase <= PH_CIRC_HEAVY;
		watch(60);
		check("timeout", 1, cnt[3]);
		check("timeout at", 1, first[3] >= 36 && first[3] <= 48);
	endtask
	task automatic t_shared(input logic [31:0] cfg, input logic [7:0] lg,
		input int exp);
		idle(cfg, FUEL_GAS);
		lag <= lg;
		fan <= 1;
		watch(30);
		check("shared", exp, cnt[1]);
	endtask
	task automatic t_irq();
		wr(REG_MASK, 32'h2);
		wr(REG_STATUS, 32'h3F);
		t_high(32'h04, FUEL_LIGHT, 1);
		check("irq on", 1, irq);
		highP <= 0;
		wr(REG_STATUS, 32'h2);
		step(1);
		check("irq off", 0, irq);
		wr(REG_MASK, 32'h0);
		t_high(32'h04, FUEL_LIGHT, 1);
		rd(REG_STATUS);
		check("sticky", 32'h2, rdata & 32'h2);
		check("masked", 0, irq);
	endtask

	initial begin
		step(10);
		resetn <= 1'b1;
		step(2);
		t_regs();
		t_high(32'h04, FUEL_LIGHT, 1);
		t_high(32'h04, FUEL_GAS, 0);
		t_high(32'h00, FUEL_LIGHT, 0);
		t_low_ts();
		t_low_act();
		t_release();
		t_go(FUEL_HEAVY, PH_CIRC_HEAVY, 1);
		t_go(FUEL_HEAVY_PILOT, PH_CIRC_HEAVY_PILOT, 1);
		t_go(FUEL_LIGHT, PH_CIRC_HEAVY, 0);
		t_go(FUEL_LIGHT_PILOT, PH_CIRC_HEAVY_PILOT, 0);
		t_timeout();
		t_shared(32'h20, 8'h02, 0);
		t_shared(32'h20, 8'h14, 1);
		t_shared(32'h40, 8'h14, 1);
		t_shared(32'h00, 8'h14, 0);
		t_irq();
		end_of_test();
	end
endmodule
